// [rtl/pit_defs.svh]
`ifndef PIT_DEFS_SVH
`define PIT_DEFS_SVH

// Word indices; byte address is four times the index
`define IDX_CONTROL        4'h0
`define IDX_CHANNEL_FORCE  4'h1
`define IDX_CHANNEL_ENABLE 4'h2
`define IDX_TIME_BASE_SEL  4'h3
`define IDX_IRQ_ENABLE     4'h4
`define IDX_TIMEOUT_FLAG   4'h5
`define IDX_MICRO_RELOAD0  4'h6
`define IDX_MICRO_RELOAD1  4'h7
`define IDX_CH_RELOAD0     4'h8
`define IDX_CH_COUNT0      4'h9

// Channel registers live at index 8 and up: bit 3 set, [2:1] channel, [0] count
`define IDX_CHAN_AREA_BIT  3
`define IDX_CHAN_MSB       2
`define IDX_CHAN_LSB       1
`define IDX_COUNT_BIT      0

// Address decode
`define ADDR_IDX_MSB       5
`define ADDR_IDX_LSB       2
`define ADDR_WIN_MSB       9
`define ADDR_WIN_LSB       6
`define ADDR_WIN_ZERO      4'h0
`define HTRANS_ACTIVE_BIT  1
`define HRESP_OKAY         1'b0

// Field positions
`define BIT_MODULE_ENABLE  7
`define MICRO_FORCE_MSB    1
`define MICRO_FORCE_LSB    0
`define COMB_FORCE_MSB     11
`define COMB_FORCE_LSB     8
`define CH_FIELD_MSB       3
`define CH_FIELD_LSB       0
`define BYTE_MSB           7
`define HALF_MSB           15

// Reset and constant values
`define RESET_BIT          1'b0
`define RESET_NIBBLE       4'h0
`define RESET_PAIR         2'h0
`define RESET_BYTE         8'h00
`define RESET_HALF         16'h0000
`define RESET_INDEX        4'h0
`define RESET_WORD         32'h0000_0000
`define ZERO_BYTE          8'h00
`define ZERO_HALF          16'h0000
`define ONE_BYTE           8'h01
`define ONE_HALF           16'h0001

`define NUM_CH             4
`define NUM_MICRO          2

`endif

// [rtl/timer_pkg.sv]
package timer_pkg;

  typedef struct packed {
    logic              module_enable;
    logic [3:0]        channel_enable;
    logic [3:0]        time_base_select;
    logic [3:0]        irq_enable;
    logic [3:0]        timeout_flag;
    logic [3:0]        trigger;
    logic [1:0][7:0]   micro_reload;
    logic [1:0][7:0]   micro_count;
    logic [1:0]        micro_run;
    logic [3:0][15:0]  channel_reload;
    logic [3:0][15:0]  channel_count;
    logic [3:0]        channel_run;
    logic              dp_sel;
    logic              dp_write;
    logic              dp_wait;
    logic [3:0]        dp_index;
    logic [31:0]       rdata;
  } state_type;

endpackage

// [rtl/periodic_interrupt_timer.sv]
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "pit_defs.svh"

// What this block does
// R1: Each micro timer keeps an 8-bit reload value; writing it never restarts counting.
// R2: Each channel keeps a 16-bit reload; writing it only takes effect at next time-out.
// R3: Software writes each channel reload as one whole access.
// R4: Count register reads return the live channel counter; writes do nothing.
// R5: A count read returns all sixteen bits coherently from one cycle.
// R6: Two 8-bit micro counters and four 16-bit channel counters form 24-bit timers.
// R7: Select bit clear ties a channel to micro base 0, set to base 1.
// R8: A channel runs only while module enable and its channel enable are set.
// R9: When an enabled channel selects a micro base, it loads and starts counting.
// R10: At micro zero, reload it and decrement every channel attached to it.
// R11: Channel and its micro counter both at zero reload the channel, set flag.
// R12: Time-out period is (micro reload+1) times (channel reload+1) clocks.
// R13: Micro counter values are never readable.
// R14: Writing one to a micro force bit reloads and restarts that micro counter.
// R15: Writing one to a channel force bit reloads and restarts that channel counter.
// R16: One write can force micro and channel counters in the same cycle.
// R17: Interrupt request follows flag while that channel's interrupt enable is set.
// R18: Writing one clears a time-out flag; writing zero leaves it.
// R19: Four trigger outputs, one per channel.
// R20: Time-out sets the flag and raises the trigger together.
// R21: The trigger stays high at least one clock after a time-out.
// R22: Software programs periods of at least two clocks when using triggers.
// R23: Software avoids spurious requests when dropping enables with requests pending.
// R24: A set and a write-one clear in one cycle leave the flag set.
// R25: Module disable clears all flags; channel disable clears that channel's flag.
// R26: Enabling an interrupt with its flag already set raises the request at once.
// R27: Channel force bits act only while enabled and always read zero.
// R28: After reset counters idle and flags, requests and triggers stay low.
module periodic_interrupt_timer (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic      [31:0] hrdata,
  output logic             hresp,
  output logic      [3:0]  timeout_irq,
  output logic      [3:0]  timeout_trigger_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [1:0] chan_of(input logic [3:0] idx);
    chan_of = idx[`IDX_CHAN_MSB:`IDX_CHAN_LSB];
  endfunction

  // Register read mux; micro counters have no read path at all
  function automatic logic [31:0] read_word(input timer_pkg::state_type s,
                                            input logic [3:0] idx);
    logic [31:0] w;
    w = `RESET_WORD;
    if (idx[`IDX_CHAN_AREA_BIT]) begin
      if (idx[`IDX_COUNT_BIT])
        w[`HALF_MSB:0] = s.channel_count[chan_of(idx)]; // R4 R5
      else
        w[`HALF_MSB:0] = s.channel_reload[chan_of(idx)];
    end else begin
      case (idx)
        `IDX_CONTROL:        w[`BIT_MODULE_ENABLE] = s.module_enable;
        `IDX_CHANNEL_ENABLE: w[`CH_FIELD_MSB:`CH_FIELD_LSB] = s.channel_enable;
        `IDX_TIME_BASE_SEL:  w[`CH_FIELD_MSB:`CH_FIELD_LSB] = s.time_base_select;
        `IDX_IRQ_ENABLE:     w[`CH_FIELD_MSB:`CH_FIELD_LSB] = s.irq_enable;
        `IDX_TIMEOUT_FLAG:   w[`CH_FIELD_MSB:`CH_FIELD_LSB] = s.timeout_flag;
        `IDX_MICRO_RELOAD0:  w[`BYTE_MSB:0] = s.micro_reload[0];
        `IDX_MICRO_RELOAD1:  w[`BYTE_MSB:0] = s.micro_reload[1];
        default:             w = `RESET_WORD; // force registers read zero
      endcase
    end
    read_word = w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // State

  timer_pkg::state_type s_reg;
  timer_pkg::state_type s_next;

  logic [3:0] set_ev;
  logic [3:0] clr_ev;
  logic [3:0] chan_force;
  logic [1:0] micro_force;
  logic [1:0] micro_zero;
  logic [1:0] micro_used;
  logic [3:0] chan_en;
  logic       bus_wr;

  always_comb begin
    s_next      = s_reg;
    s_next.trigger = `RESET_NIBBLE;
    set_ev      = `RESET_NIBBLE;
    clr_ev      = `RESET_NIBBLE;
    chan_force  = `RESET_NIBBLE;
    micro_force = `RESET_PAIR;
    micro_zero  = `RESET_PAIR;
    micro_used  = `RESET_PAIR;
    bus_wr      = s_reg.dp_sel && s_reg.dp_write;
    chan_en     = s_reg.channel_enable & {`NUM_CH{s_reg.module_enable}}; // R8

    // Register writes land in the data phase
    if (bus_wr) begin
      if (s_reg.dp_index[`IDX_CHAN_AREA_BIT]) begin
        if (!s_reg.dp_index[`IDX_COUNT_BIT])
          s_next.channel_reload[chan_of(s_reg.dp_index)] = hwdata[`HALF_MSB:0]; // R2
      end else begin
        case (s_reg.dp_index)
          `IDX_CONTROL: begin
            s_next.module_enable = hwdata[`BIT_MODULE_ENABLE];
            micro_force = hwdata[`MICRO_FORCE_MSB:`MICRO_FORCE_LSB]; // R14
            // Bits 11:8 mirror the channel force register for joint restarts
            chan_force = hwdata[`COMB_FORCE_MSB:`COMB_FORCE_LSB]; // R16
          end
          `IDX_CHANNEL_FORCE:  chan_force = hwdata[`CH_FIELD_MSB:`CH_FIELD_LSB]; // R15
          `IDX_CHANNEL_ENABLE: s_next.channel_enable = hwdata[`CH_FIELD_MSB:`CH_FIELD_LSB];
          `IDX_TIME_BASE_SEL:  s_next.time_base_select = hwdata[`CH_FIELD_MSB:`CH_FIELD_LSB];
          `IDX_IRQ_ENABLE:     s_next.irq_enable = hwdata[`CH_FIELD_MSB:`CH_FIELD_LSB];
          `IDX_TIMEOUT_FLAG:   clr_ev = hwdata[`CH_FIELD_MSB:`CH_FIELD_LSB]; // R18
          `IDX_MICRO_RELOAD0:  s_next.micro_reload[0] = hwdata[`BYTE_MSB:0]; // R1
          `IDX_MICRO_RELOAD1:  s_next.micro_reload[1] = hwdata[`BYTE_MSB:0]; // R1
          default:             s_next.module_enable = s_reg.module_enable;
        endcase
      end
    end
    chan_force = chan_force & chan_en; // R27

    // Micro time bases
    for (int b = 0; b < `NUM_MICRO; b++) begin
      for (int c = 0; c < `NUM_CH; c++) begin
        if (chan_en[c] && (s_reg.time_base_select[c] == b[0]))
          micro_used[b] = 1'b1; // R7
      end
      if (!micro_used[b]) begin
        s_next.micro_run[b] = 1'b0;
      end else if (!s_reg.micro_run[b] || micro_force[b]) begin
        s_next.micro_count[b] = s_reg.micro_reload[b]; // R9 R14
        s_next.micro_run[b]   = 1'b1;
      end else if (s_reg.micro_count[b] == `ZERO_BYTE) begin
        s_next.micro_count[b] = s_reg.micro_reload[b]; // R10 R1
        micro_zero[b]         = 1'b1;
      end else begin
        s_next.micro_count[b] = s_reg.micro_count[b] - `ONE_BYTE; // R6 R12
      end
    end

    // Channel counters tick on their selected base
    for (int c = 0; c < `NUM_CH; c++) begin
      if (!chan_en[c]) begin
        s_next.channel_run[c] = 1'b0;
      end else if (!s_reg.channel_run[c] || chan_force[c]) begin
        s_next.channel_count[c] = s_reg.channel_reload[c]; // R9 R15
        s_next.channel_run[c]   = 1'b1;
      end else if (micro_zero[s_reg.time_base_select[c]]) begin // R7 R10
        if (s_reg.channel_count[c] == `ZERO_HALF) begin
          s_next.channel_count[c] = s_reg.channel_reload[c]; // R11 R2
          set_ev[c] = 1'b1;
        end else begin
          s_next.channel_count[c] = s_reg.channel_count[c] - `ONE_HALF; // R10 R12
        end
      end
    end

    // Set beats clear; disabled channels lose their flag
    s_next.timeout_flag = (s_reg.timeout_flag & ~clr_ev) | set_ev; // R24 R18 R11
    s_next.timeout_flag = s_next.timeout_flag & s_next.channel_enable
                          & {`NUM_CH{s_next.module_enable}}; // R25
    // One-cycle pulse; a period of two clocks or more gives a clean rising edge
    // Gated by the flag so a time-out that meets a disable raises neither
    s_next.trigger = set_ev & s_next.timeout_flag; // R19 R20 R21

    // AHB-Lite slave: writes are zero wait, reads take one wait state so
    // a read right behind a write sees the written value
    if (s_reg.dp_sel && !s_reg.dp_write && s_reg.dp_wait) begin
      s_next.rdata   = read_word(s_reg, s_reg.dp_index); // R5 R13
      s_next.dp_wait = 1'b0;
    end else if (hready) begin
      s_next.dp_sel   = hsel && htrans[`HTRANS_ACTIVE_BIT]
                        && (haddr[`ADDR_WIN_MSB:`ADDR_WIN_LSB] == `ADDR_WIN_ZERO);
      s_next.dp_write = hwrite;
      s_next.dp_index = haddr[`ADDR_IDX_MSB:`ADDR_IDX_LSB];
      s_next.dp_wait  = s_next.dp_sel && !hwrite;
      if (hsel && htrans[`HTRANS_ACTIVE_BIT] && !hwrite)
        s_next.rdata = `RESET_WORD; // Outside the window reads zero
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg.module_enable    <= `RESET_BIT; // R28
      s_reg.channel_enable   <= `RESET_NIBBLE;
      s_reg.time_base_select <= `RESET_NIBBLE;
      s_reg.irq_enable       <= `RESET_NIBBLE;
      s_reg.timeout_flag     <= `RESET_NIBBLE;
      s_reg.trigger          <= `RESET_NIBBLE;
      s_reg.micro_reload     <= {`NUM_MICRO{`RESET_BYTE}};
      s_reg.micro_count      <= {`NUM_MICRO{`RESET_BYTE}};
      s_reg.micro_run        <= `RESET_PAIR;
      s_reg.channel_reload   <= {`NUM_CH{`RESET_HALF}};
      s_reg.channel_count    <= {`NUM_CH{`RESET_HALF}};
      s_reg.channel_run      <= `RESET_NIBBLE;
      s_reg.dp_sel           <= `RESET_BIT;
      s_reg.dp_write         <= `RESET_BIT;
      s_reg.dp_wait          <= `RESET_BIT;
      s_reg.dp_index         <= `RESET_INDEX;
      s_reg.rdata            <= `RESET_WORD;
    end else begin
      s_reg <= s_next;
    end
  end

  assign hreadyout           = !(s_reg.dp_sel && !s_reg.dp_write && s_reg.dp_wait);
  assign hrdata              = s_reg.rdata;
  assign hresp               = `HRESP_OKAY;
  // Dropping an enable with a request pending withdraws it at once
  assign timeout_irq         = s_reg.timeout_flag & s_reg.irq_enable; // R17 R26 R23
  assign timeout_trigger_out = s_reg.trigger; // R19

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_trigger_with_flag;
    (|s_reg.trigger) |-> ((s_reg.trigger & s_reg.timeout_flag) == s_reg.trigger);
  endproperty
  a_trigger_with_flag: assert property (p_trigger_with_flag) // R20
    else $error("trigger high without its flag");

  property p_set_beats_clear;
    (set_ev[0] && clr_ev[0] && s_next.module_enable && s_next.channel_enable[0])
      |=> s_reg.timeout_flag[0] && timeout_trigger_out[0];
  endproperty
  a_set_beats_clear: assert property (p_set_beats_clear) // R24
    else $error("flag lost when set and clear coincide");

  property p_clear_one;
    (clr_ev[0] && !set_ev[0]) |=> !s_reg.timeout_flag[0];
  endproperty
  a_clear_one: assert property (p_clear_one) // R18
    else $error("write-one did not clear flag");

  property p_disable_clears;
    (bus_wr && s_reg.dp_index == `IDX_CONTROL && !hwdata[`BIT_MODULE_ENABLE])
      |=> (s_reg.timeout_flag == `RESET_NIBBLE) && (timeout_irq == `RESET_NIBBLE);
  endproperty
  a_disable_clears: assert property (p_disable_clears) // R25
    else $error("flags survive module disable");

  property p_irq_immediate;
    ($rose(s_reg.irq_enable[0]) && s_reg.timeout_flag[0]) |-> timeout_irq[0];
  endproperty
  a_irq_immediate: assert property (p_irq_immediate) // R26
    else $error("request not raised on enable");

  property p_channel_decrement;
    (micro_zero[0] && chan_en[0] && s_reg.channel_run[0] && !chan_force[0]
     && !s_reg.time_base_select[0] && s_reg.channel_count[0] != `ZERO_HALF)
      |=> s_reg.channel_count[0] == $past(s_reg.channel_count[0]) - `ONE_HALF;
  endproperty
  a_channel_decrement: assert property (p_channel_decrement) // R10
    else $error("channel did not step on micro zero");

  property p_timeout_reload;
    s_reg.trigger[0] |-> s_reg.channel_count[0] == $past(s_reg.channel_reload[0]);
  endproperty
  a_timeout_reload: assert property (p_timeout_reload) // R11
    else $error("channel not reloaded at time-out");

  property p_micro_start;
    $rose(s_reg.micro_run[0]) |-> s_reg.micro_count[0] == $past(s_reg.micro_reload[0]);
  endproperty
  a_micro_start: assert property (p_micro_start) // R9
    else $error("micro base did not load at start");

  property p_disabled_idle;
    !chan_en[1] |=> !s_reg.channel_run[1] ##1 !timeout_trigger_out[1];
  endproperty
  a_disabled_idle: assert property (p_disabled_idle) // R8
    else $error("disabled channel still runs");

  property p_count_read;
    (s_reg.dp_sel && !s_reg.dp_write && s_reg.dp_wait && s_reg.dp_index == `IDX_CH_COUNT0)
      |=> hreadyout && hrdata[`HALF_MSB:0] == $past(s_reg.channel_count[0]);
  endproperty
  a_count_read: assert property (p_count_read) // R5
    else $error("count read incoherent");

  property p_micro_reload_kept;
    (bus_wr && s_reg.dp_index == `IDX_MICRO_RELOAD0 && micro_used[0] && s_reg.micro_run[0]
     && s_reg.micro_count[0] != `ZERO_BYTE)
      |=> s_reg.micro_count[0] == $past(s_reg.micro_count[0]) - `ONE_BYTE;
  endproperty
  a_micro_reload_kept: assert property (p_micro_reload_kept) // R1
    else $error("micro reload write restarted the count");

  property p_channel_reload_kept;
    (bus_wr && s_reg.dp_index == `IDX_CH_RELOAD0 && chan_en[0] && s_reg.channel_run[0]
     && !micro_zero[s_reg.time_base_select[0]])
      |=> s_reg.channel_count[0] == $past(s_reg.channel_count[0]);
  endproperty
  a_channel_reload_kept: assert property (p_channel_reload_kept) // R2
    else $error("channel reload write disturbed the count");

  property p_micro_force;
    (micro_force[0] && micro_used[0])
      |=> s_reg.micro_count[0] == $past(s_reg.micro_reload[0]);
  endproperty
  a_micro_force: assert property (p_micro_force) // R14
    else $error("micro force did not restart the base");

  property p_channel_force;
    chan_force[0] |=> s_reg.channel_count[0] == $past(s_reg.channel_reload[0]);
  endproperty
  a_channel_force: assert property (p_channel_force) // R15
    else $error("channel force did not reload the count");

  property p_micro_wrap;
    (micro_used[0] && s_reg.micro_run[0] && !micro_force[0]
     && s_reg.micro_count[0] == `ZERO_BYTE)
      |=> s_reg.micro_count[0] == $past(s_reg.micro_reload[0]);
  endproperty
  a_micro_wrap: assert property (p_micro_wrap) // R10
    else $error("micro base not reloaded at zero");

  property p_channel_off_clears;
    (bus_wr && s_reg.dp_index == `IDX_CHANNEL_ENABLE && !hwdata[0])
      |=> !s_reg.timeout_flag[0];
  endproperty
  a_channel_off_clears: assert property (p_channel_off_clears) // R25
    else $error("flag survives channel disable");

  c_timeout:    cover property (s_reg.trigger[0] ##[2:40] s_reg.trigger[0]);
  c_read_wait:  cover property (!hreadyout ##1 hreadyout);
  c_irq:        cover property ($rose(timeout_irq[2]));
  c_joint_force: cover property (micro_force[0] && chan_force[0]);
  c_set_clear:  cover property (set_ev[0] && clr_ev[0]);

endmodule

// [verification/periodic_interrupt_timer_tb.sv]
`timescale 1ns/1ps
`include "pit_defs.svh"
module periodic_interrupt_timer_tb;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic        hwrite;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [3:0]  timeout_irq;
  logic [3:0]  timeout_trigger_out;
  logic [3:0]  trig_prev;
  logic [31:0] seed;
  int          n_mismatch;
  int          check_count;
  int          tick [4];
  int          period [4];
  int          trig_seen [4];

  periodic_interrupt_timer u_dut (
    .hclk                (hclk),
    .hresetn             (hresetn),
    .hsel                (hsel),
    .haddr               (haddr),
    .htrans              (htrans),
    .hwrite              (hwrite),
    .hsize               (hsize),
    .hwdata              (hwdata),
    .hready              (hreadyout),
    .hreadyout           (hreadyout),
    .hrdata              (hrdata),
    .hresp               (hresp),
    .timeout_irq         (timeout_irq),
    .timeout_trigger_out (timeout_trigger_out)
  );

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [31:0] width_mask(input logic [3:0] i);
    return (i < 4'h6) ? 32'h0000_000F : (i < 4'h8) ? 32'h0000_00FF : 32'h0000_FFFF;
  endfunction

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Address phase held until hready, then data phase held until hready again
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    hsize  <= 3'b010;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [3:0] i, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, {26'h0, i, 2'b00}, d, q);
  endtask

  task automatic rd(input logic [3:0] i, output logic [31:0] q);
    bus(1'b0, {26'h0, i, 2'b00}, 32'h0000_0000, q);
  endtask

  task automatic rd_chk(input string nm, input logic [3:0] i, input logic [31:0] e);
    logic [31:0] q;
    rd(i, q);
    chk(nm, q, e);
  endtask

  // Returns one edge after the k-th new trigger so the monitor has settled
  task automatic wait_trig(input int n, input int k);
    int target;
    target = trig_seen[n] + k;
    for (int c = 0; c < 5000 && trig_seen[n] < target; c++) begin
      @(posedge hclk);
      #1;
    end
    if (trig_seen[n] < target) chk("trigger_wait", 32'h0, 32'h1);
    @(posedge hclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge hclk) begin
    for (int n = 0; n < 4; n++) begin
      tick[n]++;
      if (timeout_trigger_out[n] === 1'b1) begin
        chk("trigger_width", {31'h0, trig_prev[n]}, 32'h0);
        period[n] = tick[n];
        tick[n] = 0;
        trig_seen[n]++;
      end
    end
    trig_prev <= timeout_trigger_out;
  end

  initial begin
    repeat (20000) @(posedge hclk);
    n_mismatch++;
    $display("watchdog expired");
    test_done();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] q;
    logic [31:0] v;
    logic [3:0]  ri [9];
    int          m [2];
    int          ld;
    int          sel;
    ri = '{4'h2, 4'h3, 4'h4, 4'h6, 4'h7, 4'h8, 4'hA, 4'hC, 4'hE};
    {hsel, hwrite, htrans, haddr, hwdata, hresetn} = '0;
    hsize = 3'b010;
    seed = 32'h5817;
    n_mismatch = 0;
    check_count = 0;
    repeat (12) @(posedge hclk);
    chk("reset_outputs", {22'h0, timeout_irq, timeout_trigger_out, hresp, hreadyout}, 32'h1);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 16; i++) rd_chk("reset_reg", 4'(i), 32'h0);
    bus(1'b0, 32'h0000_0040, 32'h0, q);
    chk("unmapped_read", q, 32'h0);
    foreach (ri[k]) begin
      v = xs();
      wr(ri[k], v);
      rd_chk("readback", ri[k], v & width_mask(ri[k]));
    end
    wr(4'h9, xs());
    rd_chk("count_write", 4'h9, 32'h0);
    wr(4'h1, 32'h0000_000F);
    rd_chk("force_read", 4'h1, 32'h0);
    rd(4'h6, v);
    bus(1'b1, 32'h0000_0058, ~v, q);
    rd_chk("unmapped_write", 4'h6, v);
    $display("register test done");

    // Both time bases, random short counts, reload change mid-run
    for (int n = 0; n < 4; n++) begin
      m[0] = int'(xs() & 32'h3) + 1;
      m[1] = int'(xs() & 32'h3) + 1;
      // Reload of two or more keeps the reload write ahead of the next time-out
      ld = int'(xs() & 32'h3) + 2;
      sel = int'(xs() & 32'h1);
      wr(4'h6, 32'(m[0]));
      wr(4'h7, 32'(m[1]));
      wr(4'(8 + 2 * n), 32'(ld));
      wr(4'h3, 32'(sel << n));
      wr(4'h2, 32'(1 << n));
      wr(4'h4, 32'(1 << n));
      wr(4'h0, 32'h0000_0080);
      wait_trig(n, 3);
      chk("period", 32'(period[n]), 32'((m[sel] + 1) * (ld + 1)));
      wr(4'(8 + 2 * n), 32'(ld + 2));
      wait_trig(n, 1);
      chk("period_old", 32'(period[n]), 32'((m[sel] + 1) * (ld + 1)));
      wait_trig(n, 1);
      chk("period_new", 32'(period[n]), 32'((m[sel] + 1) * (ld + 3)));
      rd_chk("flag_set", 4'h5, 32'(1 << n));
      chk("irq_set", {28'h0, timeout_irq}, 32'(1 << n));
      rd(4'(9 + 2 * n), q);
      chk("count_range", {31'h0, q <= 32'(ld + 2)}, 32'h1);
      wr(4'h0, 32'h0);
      rd_chk("flag_module_off", 4'h5, 32'h0);
      chk("irq_module_off", {28'h0, timeout_irq}, 32'h0);
    end
    $display("period test done");

    // Long period on channel 0 leaves room for flag and force-load traffic
    wr(4'h4, 32'h0);
    wr(4'h3, 32'h0);
    wr(4'h6, 32'h0);
    wr(4'h8, 32'd200);
    wr(4'h2, 32'h1);
    wr(4'h0, 32'h0000_0080);
    wait_trig(0, 1);
    chk("irq_masked", {28'h0, timeout_irq}, 32'h0);
    wr(4'h5, 32'h0);
    rd_chk("flag_write_zero", 4'h5, 32'h1);
    wr(4'h4, 32'h1);
    #1;
    chk("irq_late_enable", {28'h0, timeout_irq}, 32'h1);
    repeat (50) @(posedge hclk);
    wr(4'h1, 32'h1);
    rd(4'h9, q);
    chk("force_reload", {31'h0, q >= 32'd195 && q <= 32'd200}, 32'h1);
    wr(4'h5, 32'h1);
    rd_chk("flag_cleared", 4'h5, 32'h0);
    chk("irq_cleared", {28'h0, timeout_irq}, 32'h0);
    wait_trig(0, 1);
    wr(4'h2, 32'h0);
    rd_chk("flag_channel_off", 4'h5, 32'h0);
    $display("flag test done");

    // Joint restart of micro 0 and channel 0, then a two-clock period
    wr(4'h6, 32'h0000_003F);
    wr(4'h8, 32'h0000_0005);
    wr(4'h2, 32'h1);
    repeat (100) @(posedge hclk);
    wr(4'h0, 32'h0000_0181);
    repeat (40) @(posedge hclk);
    rd_chk("joint_force", 4'h9, 32'h5);
    wr(4'h6, 32'h0);
    wr(4'h8, 32'h1);
    wr(4'h0, 32'h0000_0181);
    wait_trig(0, 2);
    chk("period_short", 32'(period[0]), 32'h2);
    // Clears three clocks apart: one of them meets a time-out
    wr(4'h5, 32'h1);
    @(posedge hclk);
    wr(4'h5, 32'h1);
    rd_chk("flag_set_wins", 4'h5, 32'h1);
    $display("force test done");
    test_done();
  end
endmodule
